// ==== hw/ptrg_pkg.sv ====
package ptrg_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_PAGE  = 5'h13;
  localparam logic [4:0] IDX_TRIG  = 5'h14;
  localparam logic [4:0] IDX_ESTS  = 5'h1b;
  localparam logic [4:0] IDX_EDATA = 5'h1f;
  localparam logic [4:0] IDX_TT0   = 5'h0c;
  localparam logic [4:0] IDX_TT3   = 5'h0f;
  localparam logic [4:0] IDX_TPW   = 5'h10;
  localparam logic [4:0] IDX_TPER  = 5'h11;
  localparam logic [4:0] IDX_TINIT = 5'h12;

  localparam logic [2:0] PAGE_EVT = 3'h4;
  localparam logic [2:0] PAGE_CFG = 3'h5;
  localparam logic [2:0] PAGE_RST = 3'h0;

  // ----------------------------------------------------------------
  // Trigger setup fields
  // ----------------------------------------------------------------
  localparam int TRG_PULSE  = 15;
  localparam int TRG_PER    = 14;
  localparam int TRG_LATE   = 13;
  localparam int TRG_NOTIFY = 12;
  localparam int TRG_RT_LSB = 8;
  localparam int TRG_FLIP   = 7;
  localparam int TRG_SEL_LSB = 1;
  localparam int TRG_COMMIT = 0;
  localparam int CFG_W      = 9;
  localparam logic [3:0] MAX_ROUTE = 4'hc;

  // ----------------------------------------------------------------
  // Event status fields and queue entry layout
  // ----------------------------------------------------------------
  localparam int EST_MULT    = 1;
  localparam int EST_W       = 11;
  localparam int ENT_W       = 89;
  localparam int ENT_EXT_LSB = 11;
  localparam int ENT_NS_LSB  = 27;
  localparam int ENT_SEC_LSB = 57;
  localparam logic [2:0] WI_EXT  = 3'h0;
  localparam logic [2:0] WI_NSL  = 3'h1;
  localparam logic [2:0] WI_NSH  = 3'h2;
  localparam logic [2:0] WI_SECL = 3'h3;
  localparam logic [2:0] WI_SECH = 3'h4;
  localparam logic [2:0] WI_END  = 3'h5;

  localparam int N_TRIG = 8;
  localparam int N_PINS = 12;
  localparam int EQ_DEPTH = 8;

  typedef enum logic [1:0] {
    TS_IDLE = 2'b00,
    TS_WAIT = 2'b01,
    TS_RUN  = 2'b11
  } ptrg_tstate_t;

endpackage

// ==== hw/ptrg_trig_unit.sv ====
`timescale 1ns/1ns
module ptrg_trig_unit
  import ptrg_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              load,
  input  wire logic [CFG_W-1:0]  cfg,
  input  wire logic [29:0]       t_ns,
  input  wire logic [31:0]       t_sec,
  input  wire logic [15:0]       width,
  input  wire logic [15:0]       period,
  input  wire logic              init_lvl,
  input  wire logic [29:0]       now_ns,
  input  wire logic [31:0]       now_sec,
  output logic                   trig_out,
  output logic                   done,
  output logic                   late_err
);

  // ----------------------------------------------------------------
  // Armed settings
  // ----------------------------------------------------------------
  ptrg_tstate_t     st_r;
  logic [61:0]      tgt_r;
  logic [15:0]      w_r;
  logic [15:0]      p_r;
  logic [15:0]      cnt_r;
  logic             init_r;
  logic             pulse_r;
  logic             per_r;
  logic             notify_r;
  logic             flip_r;

  wire [61:0] now_w    = {now_sec, now_ns};
  wire [61:0] ld_tgt   = {t_sec, t_ns};
  wire        ld_late  = now_w > ld_tgt;
  wire        due      = now_w >= tgt_r; // RQ25
  wire        shaped   = pulse_r & ~flip_r;
  wire        pw_end   = cnt_r == w_r - 16'h0001;
  wire        per_end  = cnt_r == p_r - 16'h0001;
  // Flip mode ignores the initial level entirely
  wire        fire_lvl = flip_r ? ~trig_out : ~init_r; // RQ20

  always_ff @(posedge mclk)
  begin
    done     <= 1'b0;
    late_err <= 1'b0;
    if (sys_rst)
    begin
      st_r     <= TS_IDLE;
      tgt_r    <= 62'h0;
      w_r      <= 16'h0;
      p_r      <= 16'h0;
      cnt_r    <= 16'h0;
      init_r   <= 1'b0;
      pulse_r  <= 1'b0;
      per_r    <= 1'b0;
      notify_r <= 1'b0;
      flip_r   <= 1'b0;
      trig_out <= 1'b0;
    end
    else if (load)
    begin
      tgt_r    <= ld_tgt;
      w_r      <= width;
      p_r      <= period;
      init_r   <= init_lvl;
      pulse_r  <= cfg[8];
      per_r    <= cfg[7];
      notify_r <= cfg[5];
      flip_r   <= cfg[0];
      cnt_r    <= 16'h0;
      if (!cfg[0])
        trig_out <= init_lvl;
      if (ld_late && !cfg[6])
      begin
        late_err <= cfg[5]; // RQ18
        st_r     <= TS_IDLE;
      end
      else
        st_r <= TS_WAIT; // RQ16
    end
    else
    begin
      unique case (st_r)
        TS_IDLE: ;
        TS_WAIT:
          if (due)
          begin
            trig_out <= fire_lvl; // RQ14
            cnt_r    <= 16'h0;
            st_r     <= TS_RUN;
          end
        TS_RUN:
        begin
          cnt_r <= cnt_r + 16'h0001;
          if (shaped && pw_end)
            trig_out <= init_r; // RQ14
          if (per_r && per_end)
          begin
            // Restart; a periodic run never raises done, so a late periodic start that fires reports nothing
            trig_out <= fire_lvl; // RQ15 RQ17
            cnt_r    <= 16'h0;
          end
          else if (!per_r && (!shaped || pw_end))
          begin
            done <= notify_r; // RQ18
            st_r <= TS_IDLE; // RQ15
          end
        end
        default: st_r <= TS_IDLE;
      endcase
    end
  end

endmodule

// ==== hw/ptrg_readout_trig.sv ====
`timescale 1ns/1ns
// Contract
// RQ1: extended status word read before timestamp words
// RQ2: multi-event flag marks extended word present
// RQ3: timestamp given as four 16-bit reads
// RQ4: order ns low, ns high, sec low, sec high
// RQ5: top two bits of ns high word zero
// RQ6: software trusts data only when status valid
// RQ7: partial timestamp reads are tolerated
// RQ8: status read advances to next queued event
// RQ9: extended word holds detect and edge per unit
// RQ10: trigger registers only on page five
// RQ11: commit bit writes fields to selected trigger
// RQ12: select without commit picks readback trigger
// RQ13: commit self-clears and reads zero
// RQ14: pulse bit gives pulse not edge
// RQ15: repeat bit gives periodic output
// RQ16: fire-if-late fires at once when past
// RQ17: late periodic start raises no notification
// RQ18: notify bit reports completion or late error
// RQ19: route field ties trigger to pin 1-12
// RQ20: flip mode toggles, ignores initial level
// RQ21: select field addresses trigger unit
// RQ22: reserved bits ignored, read zero
// RQ23: status zero means no event available
// RQ24: length field gives changed words minus one
// RQ25: trigger fires when clock reaches time
module ptrg_readout_trig
  import ptrg_pkg::*;
#(
  parameter int QDEPTH = EQ_DEPTH
)
(
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              evq_push,
  input  wire logic [EST_W-1:0]  evq_status,
  input  wire logic [15:0]       evq_ext,
  input  wire logic [29:0]       evq_ns,
  input  wire logic [31:0]       evq_sec,
  output logic                   evq_full,
  input  wire logic [29:0]       rtc_ns,
  input  wire logic [31:0]       rtc_sec,
  input  wire logic              trig_int_en,
  output logic [N_TRIG-1:0]      trig_out,
  output logic [N_PINS-1:0]      gpio_trig,
  output logic [N_TRIG-1:0]      trig_done,
  output logic [N_TRIG-1:0]      trig_late,
  output logic                   trig_int
);

  localparam int QAW = $clog2(QDEPTH);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [2:0]  page_r;
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  wire [4:0] idx      = paddr[6:2];
  wire       aligned  = (paddr[1:0] == 2'b00) && !paddr[7];
  wire       on_evt   = page_r == PAGE_EVT;
  wire       on_cfg   = page_r == PAGE_CFG; // RQ10
  wire       hit_page = aligned && idx == IDX_PAGE;
  wire       hit_ests = aligned && on_evt && idx == IDX_ESTS;
  wire       hit_edat = aligned && on_evt && idx == IDX_EDATA;
  wire       hit_trig = aligned && on_cfg && idx == IDX_TRIG; // RQ10
  wire       hit_tt   = aligned && on_cfg && idx >= IDX_TT0 && idx <= IDX_TT3;
  wire       hit_tpw  = aligned && on_cfg && idx == IDX_TPW;
  wire       hit_tper = aligned && on_cfg && idx == IDX_TPER;
  wire       hit_tini = aligned && on_cfg && idx == IDX_TINIT;
  wire       hit_any  = hit_page | hit_ests | hit_edat | hit_trig |
                        hit_tt | hit_tpw | hit_tper | hit_tini;
  wire       acc      = psel & penable;
  wire       fin      = acc & pready_r;
  wire       wr_x     = fin & pwrite & hit_any;
  wire       rd_x     = fin & ~pwrite & hit_any;

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Event queue
  // ----------------------------------------------------------------
  logic [ENT_W-1:0] q_mem [QDEPTH];
  logic [QAW-1:0]   q_wp_r;
  logic [QAW-1:0]   q_rp_r;
  logic [QAW:0]     q_cnt_r;
  logic             ests_live_r;

  wire             q_empty = q_cnt_r == '0;
  wire             q_push  = evq_push & ~evq_full;
  wire             q_pop   = rd_x & hit_ests & ests_live_r; // RQ8
  wire [ENT_W-1:0] q_head  = q_mem[q_rp_r];
  wire [ENT_W-1:0] q_new   = {evq_sec, evq_ns, evq_ext, evq_status};

  // Capture logic owns the missed count, so a push into a full queue is dropped
  assign evq_full = q_cnt_r == QDEPTH[QAW:0];

  // Status is sampled one cycle before the pop; an event pushed into an
  // empty queue in between must stay queued, not vanish behind a zero status
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ests_live_r <= 1'b0;
    else
      ests_live_r <= acc & ~pready_r & ~q_empty; // RQ23
  end

  always_ff @(posedge mclk)
  begin
    if (q_push)
      q_mem[q_wp_r] <= q_new;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      q_wp_r  <= '0;
      q_rp_r  <= '0;
      q_cnt_r <= '0;
    end
    else
    begin
      if (q_push)
        q_wp_r <= q_wp_r + 1'b1;
      if (q_pop)
        q_rp_r <= q_rp_r + 1'b1;
      if (q_push && !q_pop)
        q_cnt_r <= q_cnt_r + 1'b1;
      else if (q_pop && !q_push)
        q_cnt_r <= q_cnt_r - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Current event and data word sequencing
  // ----------------------------------------------------------------
  logic [ENT_W-1:0] cur_r;
  logic             cur_vld_r;
  logic [2:0]       widx_r;

  // Queue empty reads as all zero status
  wire [15:0] ests_val  = q_empty ? 16'h0000 :
                          {5'h00, q_head[EST_W-1:0]}; // RQ23 RQ24 RQ2
  wire        head_mult = q_head[EST_MULT];
  wire [15:0] c_ext     = cur_r[ENT_EXT_LSB +: 16]; // RQ9
  wire [29:0] c_ns      = cur_r[ENT_NS_LSB +: 30];
  wire [31:0] c_sec     = cur_r[ENT_SEC_LSB +: 32];
  logic [15:0] edat_val;

  always_comb
  begin
    edat_val = 16'h0000;
    if (cur_vld_r)
    begin
      unique case (widx_r)
        WI_EXT:  edat_val = c_ext; // RQ1
        WI_NSL:  edat_val = c_ns[15:0]; // RQ3 RQ4
        WI_NSH:  edat_val = {2'b00, c_ns[29:16]}; // RQ5
        WI_SECL: edat_val = c_sec[15:0];
        WI_SECH: edat_val = c_sec[31:16];
        default: edat_val = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cur_r     <= '0;
      cur_vld_r <= 1'b0;
      widx_r    <= WI_END;
    end
    else if (rd_x && hit_ests)
    begin
      // Any skipped words are simply abandoned here
      cur_r     <= q_head; // RQ7 RQ8
      cur_vld_r <= ests_live_r; // RQ6
      widx_r    <= head_mult ? WI_EXT : WI_NSL; // RQ1 RQ2
    end
    else if (rd_x && hit_edat && widx_r != WI_END)
      widx_r <= widx_r + 3'h1; // RQ3
  end

  // ----------------------------------------------------------------
  // Trigger setup and staging registers
  // ----------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r [N_TRIG];
  logic [2:0]       sel_r;
  logic [15:0]      tt_r [4];
  logic [15:0]      tpw_r;
  logic [15:0]      tper_r;
  logic             tini_r;
  logic [N_TRIG-1:0] load_r;

  wire [2:0]       wsel    = pwdata[TRG_SEL_LSB +: 3];
  wire             commit  = wr_x & hit_trig & pwdata[TRG_COMMIT]; // RQ11
  wire [CFG_W-1:0] wcfg    = pwdata[TRG_PULSE:TRG_FLIP]; // RQ22
  wire [CFG_W-1:0] rd_cfg  = cfg_r[sel_r];
  // Commit bit and reserved bits are never stored
  wire [15:0]      trig_val = {rd_cfg, 3'b000, sel_r, 1'b0}; // RQ13 RQ22 RQ12
  wire [1:0]       tt_i     = idx[1:0];

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sel_r  <= 3'h0;
      tpw_r  <= 16'h0001;
      tper_r <= 16'h0002;
      tini_r <= 1'b0;
      page_r <= PAGE_RST;
      load_r <= '0;
      for (int i = 0; i < 4; i++)
        tt_r[i] <= 16'h0000;
      for (int i = 0; i < N_TRIG; i++)
        cfg_r[i] <= '0;
    end
    else
    begin
      load_r <= '0;
      if (wr_x && hit_page)
        page_r <= pwdata[2:0];
      if (wr_x && hit_trig)
        sel_r <= wsel; // RQ21 RQ12
      if (commit)
      begin
        cfg_r[wsel]  <= wcfg; // RQ11 RQ21
        load_r[wsel] <= 1'b1; // RQ13
      end
      if (wr_x && hit_tt)
        tt_r[tt_i] <= pwdata[15:0];
      if (wr_x && hit_tpw)
        tpw_r <= pwdata[15:0];
      if (wr_x && hit_tper)
        tper_r <= pwdata[15:0];
      if (wr_x && hit_tini)
        tini_r <= pwdata[0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB answer (one wait state)
  // ----------------------------------------------------------------
  wire [15:0] rd_val =
    hit_page ? {13'h0000, page_r} :
    hit_ests ? ests_val :
    hit_edat ? edat_val :
    hit_trig ? trig_val :
    hit_tt   ? tt_r[tt_i] :
    hit_tpw  ? tpw_r :
    hit_tper ? tper_r :
    hit_tini ? {15'h0000, tini_r} : 16'h0000;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= acc & ~pready_r;
      prdata_r  <= (acc && !pready_r && !pwrite) ? {16'h0000, rd_val} : 32'h0000_0000;
      pslverr_r <= acc & ~pready_r & ~hit_any;
    end
  end

  // ----------------------------------------------------------------
  // Trigger units
  // ----------------------------------------------------------------
  wire [29:0] st_ns  = {tt_r[1][13:0], tt_r[0]};
  wire [31:0] st_sec = {tt_r[3], tt_r[2]};

  for (genvar u = 0; u < N_TRIG; u++)
  begin : g_unit
    ptrg_trig_unit u_trig (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .load     (load_r[u]),
      .cfg      (cfg_r[u]),
      .t_ns     (st_ns),
      .t_sec    (st_sec),
      .width    (tpw_r),
      .period   (tper_r),
      .init_lvl (tini_r),
      .now_ns   (rtc_ns),
      .now_sec  (rtc_sec),
      .trig_out (trig_out[u]),
      .done     (trig_done[u]),
      .late_err (trig_late[u])
    );
  end

  // ----------------------------------------------------------------
  // Pin routing; out-of-range route codes connect nowhere
  // ----------------------------------------------------------------
  logic [N_PINS-1:0] pin_nxt;

  for (genvar p = 0; p < N_PINS; p++)
  begin : g_pin
    logic [N_TRIG-1:0] on_pin;
    for (genvar u = 0; u < N_TRIG; u++)
    begin : g_src
      wire [3:0] rt = cfg_r[u][4:1];
      assign on_pin[u] = trig_out[u] && rt != 4'h0 && rt <= MAX_ROUTE &&
                         rt == 4'(p + 1); // RQ19
    end
    assign pin_nxt[p] = |on_pin;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      gpio_trig <= '0;
      trig_int  <= 1'b0;
    end
    else
    begin
      gpio_trig <= pin_nxt;
      trig_int  <= trig_int_en & (|(trig_done | trig_late)); // RQ18
    end
  end

endmodule

// ==== dv/ptrg_readout_trig_chk.sv ====
`timescale 1ns/1ns
module ptrg_chk
  import ptrg_pkg::*;
(
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              trig_int_en,
  input wire logic [N_TRIG-1:0] trig_done,
  input wire logic [N_TRIG-1:0] trig_late,
  input wire logic              trig_int
);
  // ----------------------------------------
  // Page tracking
  // ----------------------------------------
  localparam logic [7:0] A_PAGE = {1'b0, IDX_PAGE, 2'b00};
  localparam logic [7:0] A_TRIG = {1'b0, IDX_TRIG, 2'b00};
  logic [2:0] page_r;

  always_ff @(posedge mclk)
    if (sys_rst)
      page_r <= PAGE_RST;
    else if (pready && pwrite && paddr == A_PAGE)
      page_r <= pwdata[2:0];

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_ready_after_access: assert property ($rose(penable) && psel |=> pready)
    else $error("access not answered after one wait");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_trig_reserved: assert property (pready && !pwrite && paddr == A_TRIG |->
    prdata[6:4] == 3'h0 && !prdata[0])
    else $error("reserved or commit bits read nonzero");
  a_trig_page_only: assert property (pready && paddr == A_TRIG |->
    pslverr == (page_r != PAGE_CFG))
    else $error("trigger setup reachable off its page");
  a_int_on_note: assert property (trig_int_en && (|trig_done || |trig_late) |=> trig_int)
    else $error("notification without interrupt");
  a_int_has_cause: assert property (trig_int |-> $past(|trig_done || |trig_late))
    else $error("interrupt without notification");
endmodule

// ==== dv/ptrg_readout_trig_bench.sv ====
`timescale 1ns/1ns
module ptrg_readout_trig_bench
  import ptrg_pkg::*;
;
  logic        mclk, pready, pslverr, evq_full, trig_int, er;
  logic        sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        evq_push = 1'b0, trig_int_en = 1'b1;
  logic [7:0]  paddr = 8'h0, trig_out, trig_done, trig_late;
  logic [31:0] pwdata = 32'h0, evq_sec = 32'h0, rtc_sec = 32'h10, prdata, rd;
  logic [10:0] evq_status = 11'h0;
  logic [15:0] evq_ext = 16'h0;
  logic [29:0] evq_ns = 30'h0, rtc_ns = 30'h0;
  logic [11:0] gpio_trig;
  int          fails, compares, r, g, d, l, t;

  ptrg_readout_trig #(.QDEPTH(4)) i_dut (
    .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .evq_push, .evq_status, .evq_ext, .evq_ns, .evq_sec, .evq_full, .rtc_ns,
    .rtc_sec, .trig_int_en, .trig_out, .gpio_trig, .trig_done, .trig_late, .trig_int);

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk)
    rtc_ns <= sys_rst ? 30'h0 : rtc_ns + 30'h1;

  // ----------------------------------------
  // Access helpers
  // ----------------------------------------
  function automatic logic [7:0] ad(input logic [4:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  function automatic logic [10:0] st(input int k);
    return {3'h0, 2'(3 - k), 3'(k), 1'b0, k == 1, 1'b1};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Holds the request until pready is seen at an edge, giving up after 50 edges
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] dt);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, dt};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    chk(32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input logic e = 1'b0);
    xfer(1'b0, a, 16'h0);
    chk(rd, {16'h0, exp});
    chk(32'(er), 32'(e));
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] dt, input logic e = 1'b0);
    xfer(1'b1, a, dt);
    chk(32'(er), 32'(e));
  endtask

  task automatic tgt(input logic [31:0] s, input logic [29:0] ns);
    wr(ad(IDX_TT0), ns[15:0]);
    wr(ad(5'h0d), {2'b00, ns[29:16]});
    wr(ad(5'h0e), s[15:0]);
    wr(ad(IDX_TT3), s[31:16]);
  endtask

  task automatic push(input logic [10:0] s, input logic [29:0] ns, input logic [31:0] sec);
    @(posedge mclk);
    evq_push <= 1'b1;
    evq_status <= s;
    evq_ext <= 16'h9c63;
    evq_ns <= ns;
    evq_sec <= sec;
    @(posedge mclk);
    evq_push <= 1'b0;
  endtask

  // Counts edges and pulses of one unit and one pin
  task automatic watch(input int u, input int p, input int n);
    logic po, pg;
    r = 0;
    g = 0;
    d = 0;
    l = 0;
    po = trig_out[u];
    pg = gpio_trig[p];
    repeat (n)
    begin
      @(posedge mclk);
      if (trig_out[u] === 1'b1 && po === 1'b0)
        r++;
      if (gpio_trig[p] === 1'b1 && pg === 1'b0)
        g++;
      if (trig_done[u] === 1'b1)
        d++;
      if (trig_late[u] === 1'b1)
        l++;
      po = trig_out[u];
      pg = gpio_trig[p];
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    #80000;
    chk(32'h0, 32'h1);
    summarize();
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rdc(ad(IDX_TRIG), 16'h0, 1'b1);
    wr(ad(IDX_PAGE), 16'h5);
    rdc(ad(IDX_TRIG), 16'h0);
    rdc(ad(IDX_EDATA), 16'h0, 1'b1);
    rdc(8'h04, 16'h0, 1'b1);
    for (int i = 0; i < 8; i++)
      wr(ad(IDX_TRIG), {4'h0, 4'(i + 5), i[0], 3'h7, i[2:0], 1'b1});
    for (int i = 0; i < 8; i++)
    begin
      wr(ad(IDX_TRIG), {12'h0, i[2:0], 1'b0});
      rdc(ad(IDX_TRIG), {4'h0, 4'(i + 5), i[0], 3'h0, i[2:0], 1'b0});
    end
    t = int'(rtc_ns) + 300;
    tgt(32'h10, 30'(t));
    wr(ad(IDX_TRIG), 16'h9407);
    watch(3, 3, t - int'(rtc_ns) - 3);
    chk(r, 0);
    watch(3, 3, 40);
    chk(r, 1);
    chk(32'(trig_out[3]), 32'h0);
    chk(g, 1);
    chk(d, 1);
    chk(l, 0);
    tgt(32'h0, 30'h0);
    wr(ad(IDX_TRIG), 16'h1005);
    watch(2, 0, 20);
    chk(l, 1);
    chk(r, 0);
    wr(ad(IDX_TPER), 16'h4);
    wr(ad(IDX_TRIG), 16'hf00b);
    watch(5, 0, 40);
    chk(32'(r inside {[9:11]}), 32'h1);
    chk(l + d, 0);
    wr(ad(IDX_TINIT), 16'h1);
    for (int j = 1; j >= 0; j--)
    begin
      wr(ad(IDX_TRIG), 16'h208d);
      watch(6, 0, 10);
      chk(32'(trig_out[6]), 32'(j));
    end
    wr(ad(IDX_PAGE), 16'h4);
    rdc(ad(IDX_ESTS), 16'h0);
    rdc(ad(IDX_EDATA), 16'h0);
    for (int k = 0; k < 5; k++)
      push(st(k), 30'h2bcd_0a00 + 30'(k), 32'h1234_5670 + 32'(k));
    @(negedge mclk);
    chk(32'(evq_full), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      rdc(ad(IDX_ESTS), {5'h0, st(k)});
      if (k == 1)
        rdc(ad(IDX_EDATA), 16'h9c63);
      if (k != 2)
        rdc(ad(IDX_EDATA), 16'h0a00 + 16'(k));
      if (k == 0)
      begin
        rdc(ad(IDX_EDATA), 16'h2bcd);
        rdc(ad(IDX_EDATA), 16'h5670);
        rdc(ad(IDX_EDATA), 16'h1234);
        @(negedge mclk);
        chk(32'(evq_full), 32'h0);
      end
    end
    rdc(ad(IDX_ESTS), 16'h0);
    rdc(ad(IDX_EDATA), 16'h0);
    summarize();
  end
endmodule

bind ptrg_readout_trig ptrg_chk i_chk (
  .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .trig_int_en, .trig_done, .trig_late, .trig_int);
